// ===== rtl/dior_pkg.sv
// package: constants for the digital io conditioning router
// assumes one 50 mhz system clock and a synchronous active-low reset
package dior_pkg;

	// -------------------------------------------------------------
	// widths and counts
	// -------------------------------------------------------------
	localparam int DIOR_WORD_W = 32;
	localparam int DIOR_HALF_W = 16;
	localparam int DIOR_NUM_PHYS = 6;
	localparam int DIOR_NUM_IO = 4;
	localparam int DIOR_EXT_W = 12;
	localparam int DIOR_CODE_W = 8;
	localparam int DIOR_IDX_W = 6;

	// -------------------------------------------------------------
	// summary and control word field positions
	// -------------------------------------------------------------
	localparam int DIOR_BIT_NEG_LIMIT = 0;
	localparam int DIOR_BIT_POS_LIMIT = 1;
	localparam int DIOR_BIT_HOME = 2;
	localparam int DIOR_LEVEL_BASE = 16;
	localparam int DIOR_BIT_BRAKE = 0;
	localparam int DIOR_IN_CLK = 1;
	localparam int DIOR_IN_DIR = 2;

	// -------------------------------------------------------------
	// routing source codes
	// -------------------------------------------------------------
	localparam logic [7:0] DIOR_SRC_ZERO = 8'h00;
	localparam logic [7:0] DIOR_SRC_PHYS_LAST = 8'h10;
	localparam logic [7:0] DIOR_SRC_HALL_U = 8'h41;
	localparam logic [7:0] DIOR_SRC_HALL_W = 8'h43;
	localparam logic [7:0] DIOR_SRC_ENC_A = 8'h44;
	localparam logic [7:0] DIOR_SRC_ENC_IDX = 8'h46;
	localparam logic [7:0] DIOR_SRC_INV = 8'h80;
	localparam logic [5:0] DIOR_SUBIDX_FIRST = 6'h01;

	// -------------------------------------------------------------
	// reset values and timing
	// -------------------------------------------------------------
	localparam logic [31:0] DIOR_WORD_RST = 32'h0000_0000;
	localparam int DIOR_CLK_HZ = 50_000_000;
	localparam int DIOR_SAMPLE_US = 1000;
	localparam int DIOR_SAMPLE_CYC = DIOR_CLK_HZ / 1_000_000 * DIOR_SAMPLE_US;

endpackage

// ===== rtl/dior_smp_if.sv
// interface: sampled input levels from sampler to router core
// assumes both ends run on the same clock
`timescale 1ns/1ps
interface dior_smp_if;
	logic [15:0] phys;
	logic [2:0] hall;
	logic [2:0] enc;
	logic tick;

	modport src
	(
		output phys,
		output hall,
		output enc,
		output tick
	);
	modport dst
	(
		input phys,
		input hall,
		input enc,
		input tick
	);
endinterface

// ===== rtl/dior_sampler.sv
// sampler: synchronises pins, samples them once per interval
// assumes asynchronous pins; the interval is long, shorten it in simulation
`timescale 1ns/1ps
module dior_sampler
	import dior_pkg::*;
#(
	parameter int SAMPLE_CYCLES = DIOR_SAMPLE_CYC
)
(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [15:0] phys_pin,
	input wire logic [2:0] hall_pin,
	input wire logic [2:0] enc_pin,
	dior_smp_if.src smp
);
	localparam int N = 22;
	localparam int CNT_W = $clog2(SAMPLE_CYCLES + 1);
	localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(SAMPLE_CYCLES - 1);

	logic [N-1:0] s1_reg, s2_reg, s3_reg, stab_reg, smp_reg, deb_reg;
	logic [CNT_W-1:0] cnt_reg;
	logic tick_reg;

	// -------------------------------------------------------------
	// three-stage synchroniser
	// -------------------------------------------------------------
	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			s1_reg <= '0;
			s2_reg <= '0;
			s3_reg <= '0;
			stab_reg <= '0;
		end
		else
		begin
			s1_reg <= {enc_pin, hall_pin, phys_pin};
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			for (int i = 0; i < N; i++)
			begin
				if (s2_reg[i] == s3_reg[i])
					stab_reg[i] <= s3_reg[i];
			end
		end
	end

	// -------------------------------------------------------------
	// sample interval counter
	// -------------------------------------------------------------
	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			cnt_reg <= '0;
			tick_reg <= 1'b0;
		end
		else
		begin
			tick_reg <= (cnt_reg == CNT_LAST);
			cnt_reg <= (cnt_reg == CNT_LAST) ? '0 : cnt_reg + 1'b1;
		end
	end

	// sample and filter
	// two equal consecutive samples needed before a change is taken
	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			smp_reg <= '0;
			deb_reg <= '0;
		end
		else if (tick_reg)
		begin
			smp_reg <= stab_reg;
			for (int i = 0; i < N; i++)
			begin
				if (stab_reg[i] == smp_reg[i])
					deb_reg[i] <= stab_reg[i];
			end
		end
	end

	assign smp.phys = deb_reg[15:0];
	assign smp.hall = deb_reg[18:16];
	assign smp.enc = deb_reg[21:19];
	assign smp.tick = tick_reg;

	property p_deb_on_tick;
		@(posedge clock) disable iff (!rst_n)
		(deb_reg != $past(deb_reg)) |-> $past(tick_reg);
	endproperty
	a_deb_on_tick: assert property (p_deb_on_tick)
		else $error("filtered input changed between samples");

endmodule // dior_sampler

// ===== rtl/dior_core.sv
// router core: input conditioning, routing matrix and output drive
// assumes configuration words held stable by the controlling software
//
// Contract
// - special enable gates low bits only
// - bit0 neg limit, bit1 pos limit, bit2 home
// - inversion bit selects normally closed
// - no inversion on clock and direction inputs
// - force enable substitutes the simulated value
// - force value word supplies forced level
// - raw word shows unmodified inputs
// - input 1 at bit 0 and bit 16
// - routing enable selects per-bit sources
// - enabling routing loads equivalent default table
// - table entry n drives bit n-1
// - code 00 zero, 01-10 physical inputs
// - codes 41-43 hall, c1-c3 inverted
// - codes 44-46 encoder, c4-c6 inverted
// - top code bit inverts; 80 gives one
// - output n from control bit 15+n
// - control bit 0 drives the brake
// - polarity bit set drives low for one
// - manual override drives from manual value
// - compatibility entries have no output effect
// - first four pins configurable as outputs
// - inputs sampled each millisecond, glitches dropped
// - each input appears as special and level
`timescale 1ns/1ps
module dior_core
	import dior_pkg::*;
#(
	parameter int NUM_PHYS = DIOR_NUM_PHYS,
	parameter int SAMPLE_CYCLES = DIOR_SAMPLE_CYC
)
(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [3:0] io_i,
	output logic [3:0] io_o,
	output logic [3:0] io_oe,
	input wire logic [11:0] ext_in,
	input wire logic [2:0] hall_pin,
	input wire logic [2:0] enc_pin,
	output logic brake_o,
	output logic brake_oe,
	input wire logic [3:0] output_mask,
	input wire logic cd_mode_en,
	input wire logic [15:0] spec_en,
	input wire logic [31:0] in_invert,
	input wire logic [31:0] force_en,
	input wire logic [31:0] force_val,
	input wire logic route_en,
	input wire logic rt_wr_en,
	input wire logic [5:0] rt_wr_subidx,
	input wire logic [7:0] rt_wr_code,
	input wire logic [31:0] output_control_object,
	input wire logic [31:0] out_polarity,
	input wire logic [31:0] man_en,
	input wire logic [31:0] man_val,
	output logic [31:0] input_summary_object,
	output logic [31:0] raw_value,
	output logic route_active
);
	localparam logic [15:0] PHYS_MASK = 16'((32'h1 << NUM_PHYS) - 1);

	dior_smp_if smp ();

	dior_sampler #(
		.SAMPLE_CYCLES(SAMPLE_CYCLES)
	) u_sampler (
		.clock(clock),
		.rst_n(rst_n),
		.phys_pin({ext_in, io_i}),
		.hall_pin(hall_pin),
		.enc_pin(enc_pin),
		.smp(smp)
	);

	logic [15:0] phys_v;
	logic [7:0] table_reg [0:31];
	logic route_en_d_reg;
	logic route_mode_reg;
	logic [31:0] sum_next;
	logic [31:0] raw_next;
	logic [31:0] summary_reg;
	logic [31:0] raw_reg;
	logic [3:0] io_o_reg;
	logic [3:0] io_oe_reg;
	logic brake_lvl_reg;

	assign phys_v = smp.phys & PHYS_MASK;

	// -------------------------------------------------------------
	// source decode
	// -------------------------------------------------------------
	// physical, hall, encoder and constant sources
	function automatic logic src_sel(input logic [7:0] code, input logic [15:0] ph,
		input logic [2:0] hl, input logic [2:0] en);
		logic [6:0] c;
		logic v;
		c = code[6:0];
		v = 1'b0;
		if (c != 7'h00 && c <= DIOR_SRC_PHYS_LAST[6:0])
			v = ph[4'(c - 7'h01)];
		else if (c >= DIOR_SRC_HALL_U[6:0] && c <= DIOR_SRC_HALL_W[6:0])
			v = hl[2'(c - DIOR_SRC_HALL_U[6:0])];
		else if (c >= DIOR_SRC_ENC_A[6:0] && c <= DIOR_SRC_ENC_IDX[6:0])
			v = en[2'(c - DIOR_SRC_ENC_A[6:0])];
		return v ^ code[7];
	endfunction

	// -------------------------------------------------------------
	// routing mode and table
	// -------------------------------------------------------------
	// routing mode follows enable
	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			route_en_d_reg <= 1'b0;
			route_mode_reg <= 1'b0;
		end
		else
		begin
			route_en_d_reg <= route_en;
			route_mode_reg <= route_en;
		end
	end

	// defaults on enable
	// load wins over a write in the same cycle
	always_ff @(posedge clock)
	begin
		if (!rst_n || (route_en && !route_en_d_reg))
		begin
			for (int b = 0; b < 32; b++)
				table_reg[b] <= 8'((b % 16) + 1);
		end
		else if (rt_wr_en && rt_wr_subidx >= DIOR_SUBIDX_FIRST && rt_wr_subidx <= 6'd32)
		begin
			table_reg[5'(rt_wr_subidx - DIOR_SUBIDX_FIRST)] <= rt_wr_code;
		end
	end

	// -------------------------------------------------------------
	// per-bit input computation
	// -------------------------------------------------------------
	genvar gb;
	generate
		for (gb = 0; gb < 32; gb++)
		begin : g_bit
			localparam int IDX = gb % 16;
			localparam bit IS_CD = (IDX == DIOR_IN_CLK) || (IDX == DIOR_IN_DIR);
			logic base;
			logic sel;
			logic forced;
			logic inv_ok;
			logic lvl;
			assign base = phys_v[IDX];
			assign sel = route_mode_reg ?
				src_sel(table_reg[gb], phys_v, smp.hall, smp.enc) : base;
			assign forced = force_en[gb] ? force_val[gb] : sel;
			assign inv_ok = in_invert[gb] & ~(cd_mode_en & IS_CD);
			assign lvl = forced ^ inv_ok;
			if (gb < DIOR_LEVEL_BASE)
			begin : g_spec
				assign sum_next[gb] = lvl & spec_en[gb];
			end
			else
			begin : g_level
				assign sum_next[gb] = lvl;
			end
			assign raw_next[gb] = base;
		end
	endgenerate

	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			summary_reg <= DIOR_WORD_RST;
			raw_reg <= DIOR_WORD_RST;
		end
		else
		begin
			summary_reg <= sum_next;
			raw_reg <= raw_next;
		end
	end

	// -------------------------------------------------------------
	// outputs
	// -------------------------------------------------------------
	// compat entries unported
	always_ff @(posedge clock)
	begin
		if (!rst_n)
			io_o_reg <= '0;
		else
		begin
			for (int k = 0; k < DIOR_NUM_IO; k++)
			begin
				io_o_reg[k] <= man_en[DIOR_LEVEL_BASE + k] ?
					man_val[DIOR_LEVEL_BASE + k] :
					output_control_object[DIOR_LEVEL_BASE + k] ^
					out_polarity[DIOR_LEVEL_BASE + k];
			end
		end
	end

	always_ff @(posedge clock)
	begin
		if (!rst_n)
			io_oe_reg <= '0;
		else
			io_oe_reg <= output_mask;
	end

	always_ff @(posedge clock)
	begin
		if (!rst_n)
			brake_lvl_reg <= 1'b0;
		else if (man_en[DIOR_BIT_BRAKE])
			brake_lvl_reg <= man_val[DIOR_BIT_BRAKE];
		else
			brake_lvl_reg <= output_control_object[DIOR_BIT_BRAKE] ^
				out_polarity[DIOR_BIT_BRAKE];
	end

	// open drain: pulls low when level is 0
	assign brake_o = 1'b0;
	assign brake_oe = ~brake_lvl_reg;
	assign io_o = io_o_reg;
	assign io_oe = io_oe_reg;
	assign input_summary_object = summary_reg;
	assign raw_value = raw_reg;
	assign route_active = route_mode_reg;

	// -------------------------------------------------------------
	// checks
	// -------------------------------------------------------------
	property p_spec_gate;
		@(posedge clock) disable iff (!rst_n)
		!spec_en[DIOR_BIT_NEG_LIMIT] |=> !input_summary_object[DIOR_BIT_NEG_LIMIT];
	endproperty
	a_spec_gate: assert property (p_spec_gate)
		else $error("special bit set while its enable is off");

	property p_force;
		@(posedge clock) disable iff (!rst_n)
		force_en[16] && !in_invert[16] |=> input_summary_object[16] == $past(force_val[16]);
	endproperty
	a_force: assert property (p_force)
		else $error("forced value not reflected on bit 16");

	property p_force_inv;
		@(posedge clock) disable iff (!rst_n)
		force_en[20] && in_invert[20] |=> input_summary_object[20] == !$past(force_val[20]);
	endproperty
	a_force_inv: assert property (p_force_inv)
		else $error("inversion not applied to forced bit 20");

	property p_cd_noinv;
		@(posedge clock) disable iff (!rst_n)
		cd_mode_en && force_en[17] && in_invert[17]
			|=> input_summary_object[17] == $past(force_val[17]);
	endproperty
	a_cd_noinv: assert property (p_cd_noinv)
		else $error("clock input inverted in clock-direction mode");

	property p_raw;
		@(posedge clock) disable iff (!rst_n)
		##1 raw_value[16] == $past(phys_v[0]) && raw_value[0] == raw_value[16];
	endproperty
	a_raw: assert property (p_raw)
		else $error("raw word does not follow sampled input 1");

	property p_route_load;
		@(posedge clock) disable iff (!rst_n)
		route_en && !route_en_d_reg |=> table_reg[0] == 8'h01 && table_reg[16] == 8'h01;
	endproperty
	a_route_load: assert property (p_route_load)
		else $error("routing table not loaded with defaults");

	property p_const_one;
		@(posedge clock) disable iff (!rst_n)
		route_mode_reg && table_reg[21] == DIOR_SRC_INV && !force_en[21] && !in_invert[21]
			|=> input_summary_object[21];
	endproperty
	a_const_one: assert property (p_const_one)
		else $error("source code 80 did not give one");

	property p_manual;
		@(posedge clock) disable iff (!rst_n)
		man_en[16] |=> io_o[0] == $past(man_val[16]);
	endproperty
	a_manual: assert property (p_manual)
		else $error("manual override not applied to output 1");

	property p_polarity;
		@(posedge clock) disable iff (!rst_n)
		!man_en[17] |=> io_o[1] == ($past(output_control_object[17]) ^ $past(out_polarity[17]));
	endproperty
	a_polarity: assert property (p_polarity)
		else $error("output 2 polarity wrong");

	property p_brake;
		@(posedge clock) disable iff (!rst_n)
		!man_en[0] && !out_polarity[0] |=> brake_oe == !$past(output_control_object[0]);
	endproperty
	a_brake: assert property (p_brake)
		else $error("brake pin does not follow control bit 0");

	property p_route_mode;
		@(posedge clock) disable iff (!rst_n)
		1'b1 |=> route_active == $past(route_en);
	endproperty
	a_route_mode: assert property (p_route_mode)
		else $error("routing mode does not follow its enable");

	property p_table_write;
		@(posedge clock) disable iff (!rst_n)
		rt_wr_en && rt_wr_subidx == 6'h01 && !(route_en && !route_en_d_reg)
			|=> table_reg[0] == $past(rt_wr_code);
	endproperty
	a_table_write: assert property (p_table_write)
		else $error("entry 1 write did not land in the bit 0 slot");

	property p_pin_dir;
		@(posedge clock) disable iff (!rst_n)
		1'b1 |=> io_oe == $past(output_mask);
	endproperty
	a_pin_dir: assert property (p_pin_dir)
		else $error("pin direction does not follow the output mask");

	property p_raw_on_tick;
		@(posedge clock) disable iff (!rst_n)
		raw_value != $past(raw_value) |-> $past(smp.tick, 2);
	endproperty
	a_raw_on_tick: assert property (p_raw_on_tick)
		else $error("raw word changed away from a sample tick");

endmodule // dior_core

// ===== sim/dior_far_model.sv
// partner: switches, sensors and loads around the router pins
// assumes undriven io pins follow the switches, brake pin pulled up outside
`timescale 1ns/1ps
module dior_far_model
(
	input wire logic [5:0] sw,
	input wire logic [2:0] hall_lvl,
	input wire logic [2:0] enc_lvl,
	input wire logic [3:0] io_o,
	input wire logic [3:0] io_oe,
	input wire logic brake_o,
	input wire logic brake_oe,
	output logic [3:0] io_i,
	output logic [11:0] ext_in,
	output logic [2:0] hall_pin,
	output logic [2:0] enc_pin,
	output logic brake_lvl
);
	// driven pins read back their own level
	assign io_i = (io_oe & io_o) | (~io_oe & sw[3:0]);
	assign ext_in = {10'h000, sw[5:4]};
	assign hall_pin = hall_lvl;
	assign enc_pin = enc_lvl;
	// open drain brake, pull-up outside
	assign brake_lvl = brake_oe ? brake_o : 1'b1;
endmodule // dior_far_model

// ===== sim/test_digital_io_conditioning_router.sv
// testbench: input conditioning, routing matrix and output drive
// assumes the core with a short sample interval and the far model
`timescale 1ns/1ps
module test_digital_io_conditioning_router;
	import dior_pkg::*;
	logic clock, rst_n, cd_mode_en, route_en, rt_wr_en, route_active, brake_oe, brake_lvl;
	logic brake_o;
	logic [5:0] sw, rt_wr_subidx;
	logic [2:0] hall_lvl, enc_lvl, hall_pin, enc_pin;
	logic [3:0] io_i, io_o, io_oe, output_mask;
	logic [11:0] ext_in;
	logic [15:0] spec_en;
	logic [7:0] rt_wr_code;
	logic [31:0] in_invert, force_en, force_val, ctrl, pol, man_en, man_val, summ, raw;
	logic [7:0] codes [11] = '{8'h00, 8'h01, 8'h06, 8'h10, 8'h41, 8'h42, 8'h43, 8'h44, 8'h45,
		8'h46, 8'h80};
	int mismatches, total_checks;

	dior_core #(.SAMPLE_CYCLES(8)) u_dior_core (.clock(clock), .rst_n(rst_n), .io_i(io_i),
		.io_o(io_o), .io_oe(io_oe), .ext_in(ext_in), .hall_pin(hall_pin), .enc_pin(enc_pin),
		.brake_o(brake_o), .brake_oe(brake_oe), .output_mask(output_mask),
		.cd_mode_en(cd_mode_en),
		.spec_en(spec_en), .in_invert(in_invert), .force_en(force_en), .force_val(force_val),
		.route_en(route_en), .rt_wr_en(rt_wr_en), .rt_wr_subidx(rt_wr_subidx),
		.rt_wr_code(rt_wr_code), .output_control_object(ctrl), .out_polarity(pol),
		.man_en(man_en), .man_val(man_val), .input_summary_object(summ), .raw_value(raw),
		.route_active(route_active));
	dior_far_model u_dior_far_model (.sw(sw), .hall_lvl(hall_lvl), .enc_lvl(enc_lvl),
		.io_o(io_o), .io_oe(io_oe), .brake_o(brake_o), .brake_oe(brake_oe), .io_i(io_i),
		.ext_in(ext_in),
		.hall_pin(hall_pin), .enc_pin(enc_pin), .brake_lvl(brake_lvl));

	initial
	begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	task automatic cyc(input int n);
		repeat (n) @(negedge clock);
	endtask

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e)
		begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask

	function automatic logic [31:0] exp_sum();
		logic [31:0] r;
		logic v;
		for (int b = 0; b < 32; b++)
		begin
			v = (b % 16 < 6) ? sw[b % 16] : 1'b0;
			if (force_en[b]) v = force_val[b];
			if (in_invert[b] && !(cd_mode_en && (b % 16 == 1 || b % 16 == 2))) v = ~v;
			if (b < 16) v = v & spec_en[b];
			r[b] = v;
		end
		return r;
	endfunction

	function automatic logic src(input logic [7:0] c);
		logic v;
		v = 1'b0;
		if (c[6:0] >= 7'h01 && c[6:0] <= 7'h06) v = sw[c[6:0] - 7'h01];
		if (c[6:0] >= 7'h41 && c[6:0] <= 7'h43) v = hall_lvl[c[1:0] - 2'h1];
		if (c[6:0] >= 7'h44 && c[6:0] <= 7'h46) v = enc_lvl[c[1:0]];
		return v ^ c[7];
	endfunction

	task automatic wr(input logic [5:0] s, input logic [7:0] c);
		rt_wr_en = 1'b1;
		rt_wr_subidx = s;
		rt_wr_code = c;
		cyc(1);
		rt_wr_en = 1'b0;
		cyc(3);
	endtask

	task automatic print_verdict;
		if (mismatches == 0 && total_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_levels;
		sw = 6'h25;
		cyc(40);
		chk("raw", {10'h000, sw, 10'h000, sw}, raw);
		chk("summary unmasked", exp_sum(), summ);
		spec_en = 16'h0007;
		cyc(3);
		chk("summary special", exp_sum(), summ);
		sw = 6'h27;
		cyc(2);
		sw = 6'h25;
		repeat (24)
		begin
			cyc(1);
			chk("summary glitch", exp_sum(), summ);
		end
	endtask

	task automatic t_invert;
		in_invert = 32'hffff_ffff;
		cyc(3);
		chk("summary inverted", exp_sum(), summ);
		chk("raw inverted", {10'h000, sw, 10'h000, sw}, raw);
		cd_mode_en = 1'b1;
		cyc(3);
		chk("summary step inputs", exp_sum(), summ);
		force_en = 32'h0013_0009;
		force_val = 32'h0012_0008;
		cyc(3);
		chk("summary forced inv", exp_sum(), summ);
		in_invert = 32'h0;
		cyc(3);
		chk("summary forced", exp_sum(), summ);
		force_en = 32'h0;
		cd_mode_en = 1'b0;
	endtask

	task automatic t_route;
		logic [31:0] e;
		logic [7:0] c;
		route_en = 1'b1;
		hall_lvl = 3'h5;
		enc_lvl = 3'h2;
		cyc(40);
		chk("route active", 32'h1, {31'h0, route_active});
		chk("summary default table", exp_sum(), summ);
		for (int i = 0; i < 11; i++)
		begin
			for (int k = 0; k < 2; k++)
			begin
				c = codes[i] | {k[0], 7'h00};
				wr(6'h11, c);
				e = exp_sum();
				e[16] = src(c);
				chk("routed bit16", e, summ);
			end
		end
		wr(6'h01, 8'h00);
		e[0] = 1'b0;
		chk("routed bit0", e, summ);
		wr(6'h16, 8'h00);
		e[21] = 1'b0;
		chk("routed bit21 zero", e, summ);
		wr(6'h16, 8'h80);
		e[21] = 1'b1;
		chk("routed bit21 one", e, summ);
		// mode left on, no back and forth
	endtask

	task automatic o_case(input logic [31:0] c, p, me, mv);
		logic [31:0] lv;
		ctrl = c;
		pol = p;
		man_en = me;
		man_val = mv;
		lv = (me & mv) | (~me & (c ^ p));
		cyc(3);
		chk("io_o", {28'h0, lv[19:16]}, {28'h0, io_o});
		chk("io_oe", {28'h0, output_mask}, {28'h0, io_oe});
		chk("brake", {31'h0, lv[0]}, {31'h0, brake_lvl});
	endtask

	initial
	begin
		{rst_n, cd_mode_en, route_en, rt_wr_en, sw, rt_wr_subidx, hall_lvl, enc_lvl} = '0;
		{output_mask, spec_en, rt_wr_code, in_invert, force_en, force_val} = '0;
		{ctrl, pol, man_en, man_val} = '0;
		mismatches = 0;
		total_checks = 0;
		cyc(10);
		chk("reset summary", 32'h0, summ);
		chk("reset brake_oe", 32'h1, {31'h0, brake_oe});
		rst_n = 1'b1;
		cyc(1);
		t_levels();
		t_invert();
		t_route();
		output_mask = 4'hf;
		o_case(32'h000a_0001, 32'h0, 32'h0, 32'h0);
		o_case(32'h000a_0001, 32'h0003_0001, 32'h0, 32'h0);
		o_case(32'h000a_0001, 32'h0003_0001, 32'h0009_0001, 32'h0001_0000);
		print_verdict();
	end

	initial
	begin
		#100_000;
		mismatches++;
		print_verdict();
	end
endmodule // test_digital_io_conditioning_router
